// ### verilog/csrchk_pkg.sv
// package for the register access checker: address fields, privilege codes,
// access kinds, range constants and the carrier structs shared by the two modules.
// assumes nothing of its surroundings beyond a single core clock.
package csrchk_pkg;

    // address layout
    localparam int CSRCHK_ADDR_W = 12;
    localparam int CSRCHK_RO_MSB = 11;
    localparam int CSRCHK_RO_LSB = 10;
    localparam int CSRCHK_PRV_MSB = 9;
    localparam int CSRCHK_PRV_LSB = 8;
    localparam int CSRCHK_NS_MSB = 7;
    localparam int CSRCHK_NS_LSB = 6;
    localparam int CSRCHK_DATA_W = 32;
    localparam logic [1:0] CSRCHK_RO_CODE = 2'h3;
    localparam logic [1:0] CSRCHK_SHADOW_CODE = 2'h2;
    localparam logic [1:0] CSRCHK_NS_CODE = 2'h3;

    // user non-standard spans
    localparam logic [11:0] CSRCHK_U_NS_RW_LO = 12'h0800;
    localparam logic [11:0] CSRCHK_U_NS_RW_HI = 12'h08ff;
    localparam logic [11:0] CSRCHK_U_NS_RO_LO = 12'h0cc0;
    localparam logic [11:0] CSRCHK_U_NS_RO_HI = 12'h0cff;

    // debug spans at machine level
    localparam logic [11:0] CSRCHK_DBG_STD_LO = 12'h07a0;
    localparam logic [11:0] CSRCHK_DBG_STD_HI = 12'h07af;
    localparam logic [11:0] CSRCHK_DBG_ONLY_LO = 12'h07b0;
    localparam logic [11:0] CSRCHK_DBG_ONLY_HI = 12'h07bf;

    // reset values
    localparam logic [31:0] CSRCHK_DATA_RST = 32'h0000_0000;

    // privilege encoding, machine highest
    typedef enum logic [1:0] {
        CSRCHK_PRV_U = 2'h0,
        CSRCHK_PRV_S = 2'h1,
        CSRCHK_PRV_H = 2'h2,
        CSRCHK_PRV_M = 2'h3
    } csrchk_prv_t;

    // read-modify-write operation of the access instruction
    typedef enum logic [1:0] {
        CSRCHK_OP_WRITE = 2'h1,
        CSRCHK_OP_SET = 2'h2,
        CSRCHK_OP_CLEAR = 2'h3
    } csrchk_op_t;

    // request from the pipeline
    typedef struct packed {
        logic valid;
        logic [11:0] addr;
        csrchk_op_t op;
        logic wr_en;             // zero when the source operand means no write
        logic [31:0] wdata;
        logic [4:0] rd;
        csrchk_prv_t prv;
        logic dbg_mode;
    } csrchk_req_t;

    // decode of one address
    typedef struct packed {
        logic read_only;
        logic [1:0] min_prv;
        logic nonstd;
        logic shadow;
        logic dbg_std;
        logic dbg_only;
    } csrchk_dec_t;

    // answer to the pipeline
    typedef struct packed {
        logic valid;
        logic illegal;
        logic [31:0] rdata;
        logic rd_we;
        logic [4:0] rd;
        csrchk_dec_t cls;
    } csrchk_rsp_t;

endpackage

// ### verilog/csrchk_decode.sv
// address classifier for the register access checker.
// purely combinational; the caller registers whatever it needs.
`timescale 1ns/1ps
`default_nettype none
module csrchk_decode
    import csrchk_pkg::*;
(
    // address in
    input wire logic [11:0] addr,
    // classification out
    output csrchk_dec_t dec
);

    // field split and range compare
    always_comb begin
        dec = '0;
        dec.read_only = (addr[CSRCHK_RO_MSB:CSRCHK_RO_LSB] == CSRCHK_RO_CODE);   // [RULE_02]
        dec.min_prv = addr[CSRCHK_PRV_MSB:CSRCHK_PRV_LSB];                       // [RULE_03]
        if (addr[CSRCHK_PRV_MSB:CSRCHK_PRV_LSB] == CSRCHK_PRV_U) begin
            dec.nonstd = (addr >= CSRCHK_U_NS_RW_LO && addr <= CSRCHK_U_NS_RW_HI) ||
                         (addr >= CSRCHK_U_NS_RO_LO && addr <= CSRCHK_U_NS_RO_HI); // [RULE_10]
        end else begin
            dec.nonstd = (addr[CSRCHK_NS_MSB:CSRCHK_NS_LSB] == CSRCHK_NS_CODE);     // [RULE_10]
            dec.shadow = (addr[CSRCHK_RO_MSB:CSRCHK_RO_LSB] == CSRCHK_SHADOW_CODE); // [RULE_11]
        end
        dec.dbg_std = (addr >= CSRCHK_DBG_STD_LO && addr <= CSRCHK_DBG_STD_HI);      // [RULE_13]
        dec.dbg_only = (addr >= CSRCHK_DBG_ONLY_LO && addr <= CSRCHK_DBG_ONLY_HI);   // [RULE_13]
    end

endmodule
`default_nettype wire

// ### verilog/csrchk_top.sv
// register access checker: holds a small register space, checks each access
// for existence, privilege and writability, and performs the read-modify-write.
// assumes the pipeline issues at most one access per cycle on the core clock
// and holds the destination write until the answer arrives.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE_01 - decode a twelve bit register address
// RULE_02 - top bits 11 mean read-only
// RULE_03 - bits 9:8 give lowest allowed privilege
// RULE_04 - privilege codes user to machine, 00-11
// RULE_05 - equal or higher privilege is granted
// RULE_06 - absent register raises illegal instruction
// RULE_07 - low privilege or read-only write illegal
// RULE_08 - writes to read-only bits silently dropped
// RULE_09 - optional invisible trap by higher level
// RULE_10 - classify standard versus non-standard addresses
// RULE_11 - top bits 10 above user are shadows
// RULE_12 - shadow usable by all higher levels
// RULE_13 - debug standard and debug-only spans
// RULE_14 - machine access to debug span illegal
// RULE_15 - debug mode ranks above machine
// RULE_16 - each access is atomic read-modify-write
// RULE_17 - illegal reported same cycle, updates suppressed; the registered answer here comes one cycle later
module csrchk_top
    import csrchk_pkg::*;
#(
    parameter int NUM_REGS = 16,
    // implemented addresses, one per entry
    parameter logic [NUM_REGS*12-1:0] REG_ADDRS = '0,
    // writable bit mask per entry; zero bits are read-only bits
    parameter logic [NUM_REGS*32-1:0] REG_WMASK = '1,
    // when set, machine access to the debug span is refused
    parameter bit DBG_SPAN_ILLEGAL = 1'b1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pipeline request
    input wire csrchk_req_t req,
    // higher level asks to intercept otherwise legal lower level accesses made at exactly the register's lowest allowed privilege
    input wire logic intercept_en,
    // pipeline answer
    output csrchk_rsp_t rsp,
    output logic intercept_q
);

    localparam int IDX_W = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

    csrchk_dec_t dec;
    logic [NUM_REGS-1:0] hit;
    logic [NUM_REGS*32-1:0] regs_q, regs_d;
    logic [IDX_W-1:0] idx;
    logic exists;
    logic [2:0] eff_prv;
    logic writes;
    logic prv_bad;
    logic ro_bad;
    logic dbg_bad;
    logic illegal;
    logic trap;
    logic [31:0] old_val;
    logic [31:0] new_val;
    logic [31:0] mask;
    csrchk_rsp_t rsp_d;
    logic intercept_d;

    // address classification
    csrchk_decode u_dec (
        .addr(req.addr),   // [RULE_01]
        .dec(dec)
    );

    // per entry address match
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_hit
            assign hit[g] = (REG_ADDRS[g*12 +: 12] == req.addr);
        end
    endgenerate

    // select the hit entry and check the access
    always_comb begin
        idx = '0;
        exists = 1'b0;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (hit[i] && !exists) begin
                idx = IDX_W'(i);
                exists = 1'b1;
            end
        end
        // debug mode counts as one level above machine
        eff_prv = req.dbg_mode ? 3'h4 : {1'b0, req.prv};                     // [RULE_04] [RULE_15]
        writes = req.wr_en;
        prv_bad = (eff_prv < {1'b0, dec.min_prv});                           // [RULE_05] [RULE_12]
        ro_bad = writes && dec.read_only;                                    // [RULE_07]
        dbg_bad = (dec.dbg_only && !req.dbg_mode) ||
                  (DBG_SPAN_ILLEGAL && (dec.dbg_std || dec.dbg_only) && !req.dbg_mode); // [RULE_14] [RULE_15]
        illegal = !exists || prv_bad || ro_bad || dbg_bad;                   // [RULE_06] [RULE_07]
        trap = intercept_en && !illegal && (eff_prv > {1'b0, dec.min_prv}) == 1'b0 &&
               req.prv != CSRCHK_PRV_M && !req.dbg_mode;                     // [RULE_09]
        old_val = regs_q[idx*32 +: 32];
        mask = REG_WMASK[idx*32 +: 32];
        unique case (req.op)
            CSRCHK_OP_SET: new_val = old_val | req.wdata;
            CSRCHK_OP_CLEAR: new_val = old_val & ~req.wdata;
            default: new_val = req.wdata;
        endcase
        // read-only bits keep their old value
        new_val = (new_val & mask) | (old_val & ~mask);                      // [RULE_08]
    end

    // register update and answer
    always_comb begin
        regs_d = regs_q;
        rsp_d = '0;
        intercept_d = 1'b0;
        if (req.valid) begin
            rsp_d.valid = 1'b1;
            rsp_d.illegal = illegal;                                         // [RULE_17]
            rsp_d.rd = req.rd;
            rsp_d.cls = dec;
            rsp_d.rdata = (illegal || trap) ? 32'h0000_0000 : old_val;
            rsp_d.rd_we = !illegal && !trap;                                 // [RULE_17]
            intercept_d = trap;                                              // [RULE_09]
            if (!illegal && !trap && writes) begin
                regs_d[idx*32 +: 32] = new_val;                              // [RULE_16]
            end
        end
    end

    // state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regs_q <= {NUM_REGS{CSRCHK_DATA_RST}};
            rsp <= '0;
            intercept_q <= 1'b0;
        end else begin
            regs_q <= regs_d;
            rsp <= rsp_d;
            intercept_q <= intercept_d;
        end
    end

    // write to a read-only address always answers illegal next cycle
    property p_ro_write;
        @(posedge clk) disable iff (rst)
        (req.valid && req.wr_en && req.addr[11:10] == 2'h3) |=> (rsp.valid && rsp.illegal && !rsp.rd_we);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write not refused"); // [RULE_07]

    // too low a privilege is refused
    property p_prv;
        @(posedge clk) disable iff (rst)
        (req.valid && !req.dbg_mode && req.prv < req.addr[9:8]) |=> rsp.illegal;
    endproperty
    a_prv: assert property (p_prv) else $error("low privilege access not refused"); // [RULE_05]

    // refused accesses never change the register space
    property p_no_update;
        @(posedge clk) disable iff (rst)
        (req.valid && illegal) |=> (regs_q == $past(regs_q));
    endproperty
    a_no_update: assert property (p_no_update) else $error("illegal access changed state"); // [RULE_17]

    // unimplemented address refused
    property p_absent;
        @(posedge clk) disable iff (rst)
        (req.valid && hit == '0) |=> (rsp.illegal && rsp.rdata == 32'h0000_0000);
    endproperty
    a_absent: assert property (p_absent) else $error("absent register not refused"); // [RULE_06]

    // debug-only span refused outside debug mode
    property p_dbg;
        @(posedge clk) disable iff (rst)
        (req.valid && !req.dbg_mode && req.addr[11:4] == 8'h7b) |=> rsp.illegal;
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug span reached outside debug mode"); // [RULE_15]

    // machine access to the debug span refused
    property p_dbg_m;
        @(posedge clk) disable iff (rst)
        (req.valid && DBG_SPAN_ILLEGAL && !req.dbg_mode && req.addr[11:5] == 7'h3d) |=> rsp.illegal;
    endproperty
    a_dbg_m: assert property (p_dbg_m) else $error("machine debug span access allowed"); // [RULE_14]

    // a legal write lands within one cycle
    property p_write;
        @(posedge clk) disable iff (rst)
        (req.valid && !illegal && !trap && writes) |=> (regs_q[$past(idx)*32 +: 32] == $past(new_val));
    endproperty
    a_write: assert property (p_write) else $error("legal write not applied"); // [RULE_16]

    // masked bits keep their old value
    property p_mask;
        @(posedge clk) disable iff (rst)
        req.valid |=> ((regs_q[$past(idx)*32 +: 32] & ~$past(mask)) == ($past(old_val) & ~$past(mask)));
    endproperty
    a_mask: assert property (p_mask) else $error("read-only bit changed"); // [RULE_08]

    // classification of user non-standard read-write span
    property p_ns;
        @(posedge clk) disable iff (rst)
        (req.valid && req.addr[11:8] == 4'h8) |=> rsp.cls.nonstd;
    endproperty
    a_ns: assert property (p_ns) else $error("user non-standard span misclassified"); // [RULE_10]

    // shadow addresses above user level are classified as such
    property p_shadow;
        @(posedge clk) disable iff (rst)
        (req.valid && req.addr[11:10] == 2'h2 && req.addr[9:8] != 2'h0) |=> rsp.cls.shadow;
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow address misclassified"); // [RULE_11]

    // an intercepted access is neither refused nor written back
    property p_intercept;
        @(posedge clk) disable iff (rst)
        (req.valid && intercept_en && !illegal && !req.dbg_mode && req.prv != CSRCHK_PRV_M &&
         req.prv == req.addr[9:8]) |=> (intercept_q && !rsp.illegal && !rsp.rd_we);
    endproperty
    a_intercept: assert property (p_intercept) else $error("interception not shown as expected"); // [RULE_09]

    // no request, no answer
    property p_idle;
        @(posedge clk) disable iff (rst)
        !req.valid |=> (!rsp.valid && !intercept_q);
    endproperty
    a_idle: assert property (p_idle) else $error("answer without a request"); // [RULE_17]

endmodule
`default_nettype wire

// ### test/csrchk_pipe_model.sv
// pipeline model for the register access checker: issues one access at a time
// and keeps the answer that comes back for it.
// assumes the core clock and the request and answer carriers of the package.
`timescale 1ns/1ps
`default_nettype none
module csrchk_pipe_model
    import csrchk_pkg::*;
(
    // clock
    input wire logic clk,
    // request out, answer in
    output var csrchk_req_t req,
    input wire csrchk_rsp_t rsp,
    input wire logic intercept_q
);
    csrchk_rsp_t got;
    logic got_icp;

    // idle request from time zero
    initial req = '0;

    // one whole access per request, driven on a falling edge
    task automatic access(input logic [11:0] a, input logic [1:0] op, input logic wr,
                          input logic [31:0] wd, input logic [1:0] prv, input logic dbg);
        @(negedge clk);
        req = '{valid: 1'b1, addr: a, op: csrchk_op_t'(op), wr_en: wr, wdata: wd, rd: 5'h0a,
                prv: csrchk_prv_t'(prv), dbg_mode: dbg};
        @(negedge clk);
        // the answer stands for this one cycle only, so take it before letting go
        got = rsp;
        got_icp = intercept_q;
        // released address and data lines carry the inverse so a stale value never passes
        req.valid = 1'b0;
        req.addr = ~a;
        req.wdata = ~wd;
    endtask
endmodule
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the register access checker: privilege, writability,
// existence, classification, debug spans and interception.
// assumes the package, the checker and the pipeline model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb
    import csrchk_pkg::*;
;
    localparam int NREG = 7;
    // implemented addresses, entry 0 in the low bits
    localparam logic [NREG*12-1:0] ADDRS = {12'h800, 12'h7b0, 12'h7a0, 12'h900, 12'h300, 12'hc00, 12'h040};
    // entry 2 has only its low byte writable
    localparam logic [NREG*32-1:0] WMASK = {{4{32'hffff_ffff}}, 32'h0000_00ff, {2{32'hffff_ffff}}};
    localparam logic [1:0] OW = CSRCHK_OP_WRITE;
    localparam logic [1:0] OS = CSRCHK_OP_SET;
    localparam logic [1:0] OC = CSRCHK_OP_CLEAR;
    localparam logic [1:0] PU = CSRCHK_PRV_U;
    localparam logic [1:0] PS = CSRCHK_PRV_S;
    localparam logic [1:0] PM = CSRCHK_PRV_M;
    logic clk = 1'b0;
    logic rst;
    logic intercept_en;
    logic intercept_q;
    logic icp_exp;
    csrchk_req_t req;
    csrchk_rsp_t rsp;
    int bad_count;
    int compares;

    // core clock, 5 ns period
    always #2.5 clk = ~clk;

    csrchk_top #(.NUM_REGS(NREG), .REG_ADDRS(ADDRS), .REG_WMASK(WMASK), .DBG_SPAN_ILLEGAL(1'b1)) u_csrchk_top (
        .clk(clk), .rst(rst), .req(req), .intercept_en(intercept_en), .rsp(rsp), .intercept_q(intercept_q));
    csrchk_pipe_model u_csrchk_pipe_model (.clk(clk), .req(req), .rsp(rsp), .intercept_q(intercept_q));

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one access and the judgement of its answer
    task automatic acc(input logic [11:0] a, input logic [1:0] op, input logic wr, input logic [31:0] wd,
                       input logic [1:0] prv, input logic dbg, input logic ill, input logic [31:0] rd);
        csrchk_rsp_t g;
        u_csrchk_pipe_model.access(a, op, wr, wd, prv, dbg);
        g = u_csrchk_pipe_model.got;
        chk(g.valid, 1'b1);
        chk(g.rd, 5'h0a);
        chk(g.illegal, ill);
        chk(g.rd_we, !(ill | icp_exp));
        chk(u_csrchk_pipe_model.got_icp, icp_exp);
        chk(g.rdata, rd);
    endtask

    // classification of the last answer
    task automatic cls(input logic [6:0] exp);
        chk(u_csrchk_pipe_model.got.cls, exp);
    endtask

    // user register from every level, machine register only from machine
    task automatic s_priv();
        acc(12'h040, OW, '1, 32'h1234_5678, PU, '0, '0, '0);
        for (int p = 0; p < 4; p++) begin
            acc(12'h040, OS, '0, '0, 2'(p), '0, '0, 32'h1234_5678);
            acc(12'h300, OS, '0, '0, 2'(p), '0, p != 3, '0);
        end
        acc(12'h900, OS, '0, '0, PU, '0, '1, '0);
    endtask

    // read-only registers and absent addresses
    task automatic s_ro();
        acc(12'hc00, OS, '0, '0, PU, '0, '0, '0);
        acc(12'hc00, OW, '1, 32'hffff_ffff, PM, '0, '1, '0);
        acc(12'h041, OS, '0, '0, PM, '0, '1, '0);
        acc(12'hfff, OS, '0, '0, PM, '0, '1, '0);
    endtask

    // read-only bits dropped, each operation a read-modify-write
    task automatic s_bits();
        acc(12'h300, OW, '1, 32'hffff_ffff, PM, '0, '0, '0);
        acc(12'h300, OC, '1, 32'h0000_000f, PM, '0, '0, 32'h0000_00ff);
        acc(12'h300, OS, '1, 32'h0000_0f01, PM, '0, '0, 32'h0000_00f0);
        acc(12'h300, OS, '0, '0, PM, '0, '0, 32'h0000_00f1);
    endtask

    // standard, non-standard and shadow classes
    task automatic s_cls();
        acc(12'h800, OW, '1, 32'h0000_0005, PU, '0, '0, '0);
        cls(7'b0001000);
        acc(12'h040, OS, '0, '0, PU, '0, '0, 32'h1234_5678);
        cls(7'b0000000);
        acc(12'h900, OW, '1, 32'ha5a5_a5a5, PS, '0, '0, '0);
        cls(7'b0010100);
        acc(12'h900, OS, '0, '0, PM, '0, '0, 32'ha5a5_a5a5);
    endtask

    // debug spans refused at machine level, open in debug mode
    task automatic s_dbg();
        acc(12'h7a0, OS, '0, '0, PM, '0, '1, '0);
        acc(12'h7b0, OS, '0, '0, PM, '0, '1, '0);
        acc(12'h7a0, OW, '1, 32'h0000_00aa, PM, '1, '0, '0);
        cls(7'b0110010);
        acc(12'h7b0, OW, '1, 32'h0000_00bb, PM, '1, '0, '0);
        cls(7'b0110001);
        acc(12'h7a0, OS, '0, '0, PM, '1, '0, 32'h0000_00aa);
    endtask

    // interception leaves no trace; a refused write changes nothing
    task automatic s_int();
        @(negedge clk);
        intercept_en = '1;
        icp_exp = '1;
        acc(12'h040, OW, '1, 32'hffff_0000, PU, '0, '0, '0);
        icp_exp = '0;
        acc(12'h040, OS, '0, '0, PM, '0, '0, 32'h1234_5678);
        intercept_en = '0;
        acc(12'h300, OW, '1, '0, PU, '0, '1, '0);
        acc(12'h300, OS, '0, '0, PM, '0, '0, 32'h0000_00f1);
    endtask

    // verdict and end of run
    task automatic wrap_up();
        $display("compares %0d bad %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard, far beyond the roughly seventy cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    // reset, then the scenarios
    initial begin
        rst = 1'b1;
        intercept_en = '0;
        icp_exp = '0;
        bad_count = 0;
        compares = 0;
        repeat (5) @(negedge clk);
        chk(rsp.valid, '0);
        chk(intercept_q, '0);
        rst = '0;
        s_priv();
        s_ro();
        s_bits();
        s_cls();
        s_dbg();
        s_int();
        wrap_up();
    end
endmodule
`default_nettype wire
